//--- irq_flags_pkg.sv
// constants, register indices and carrier types of the interrupt flag block
// assumes one system clock; the cpu core drives flag accesses and acceptances
// Notes on behaviour
// - source sets flag, acceptance clears it
// - set flag and enable raise vectored request, except key and watch flags
// - software-set flag acts like hardware request
// - reset clears all request and enable flags
// - bit and nibble accesses reach flags directly
// - interval and dual-edge share vector, special clear
// - internal pulses set internal request flags
// - dual-edge pin sets flag on both edges
// - mode registers choose ext pin a/b edge
// - ext pin a drops pulses under two samples
// - mode bit 3 picks sample clock
// - reset clears ext0/ext1 modes to rising
// - ext pin a frozen during standby
// - mode zero: ext pin c rising edge
// - key mode: selected keys falling edge
// - any selected key low blocks others
// - reset clears key mode register to rising
// - mode registers written as nibbles
// - test-and-clear returns flag, clears it
// - fixed priority vrq1 first, vectors 2..c
// - global enable gates all vectored requests
package irq_flags_pkg;
  // flag positions within the request and enable vectors
  localparam int NUM_FLAGS = 9;
  localparam int F_INTERVAL = 0;
  localparam int F_DUAL = 1;
  localparam int F_EXT0 = 2;
  localparam int F_EXT1 = 3;
  localparam int F_SERIAL = 4;
  localparam int F_COUNTER = 5;
  localparam int F_PULSE = 6;
  localparam int F_WATCH = 7;
  localparam int F_KEY = 8;
  // nibble register indices
  localparam logic [3:0] IDX_EXT0_MODE = 4'h0;
  localparam logic [3:0] IDX_EXT1_MODE = 4'h1;
  localparam logic [3:0] IDX_EXT2_MODE = 4'h2;
  localparam logic [3:0] IDX_REQ_LO = 4'h3;
  localparam logic [3:0] IDX_REQ_MID = 4'h4;
  localparam logic [3:0] IDX_REQ_HI = 4'h5;
  localparam logic [3:0] IDX_EN_LO = 4'h6;
  localparam logic [3:0] IDX_EN_MID = 4'h7;
  localparam logic [3:0] IDX_EN_HI = 4'h8;
  // single-bit select: request flags 0..8, enable flags 9..17
  localparam logic [4:0] BIT_EN_BASE = 5'h09;
  // reset values of mode registers
  localparam logic [3:0] MODE_RESET = 4'h0;
  // edge select codes in mode bits [1:0]
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  localparam int EXT0_CLK_SEL_BIT = 3;
  // sample divider of the slow ext pin a clock
  localparam int SLOW_SAMPLE_DIV = 64;
  // vector table addresses of vrq1..vrq6
  localparam logic [15:0] VEC_ADDR_BASE = 16'h0002;
  localparam logic [15:0] VEC_ADDR_STEP = 16'h0002;
  // bit operations
  typedef enum logic [1:0] {
    BIT_NOP = 2'h0,
    BIT_SET = 2'h1,
    BIT_CLR = 2'h3,
    BIT_TEST_CLR = 2'h2
  } bit_op_t;
  // one-cycle request pulses from on-chip sources
  typedef struct packed {
    logic interval_tick;
    logic serial_done;
    logic counter_match;
    logic pulse_gen_match;
    logic watch_tick;
  } int_src_t;
  // external pins
  typedef struct packed {
    logic [7:0] key_inputs;
    logic ext_irq_pin_dual;
    logic ext_irq_pin_c;
    logic ext_irq_pin_b;
    logic ext_irq_pin_a;
  } ext_pins_t;
endpackage

//--- irq_flags.sv
// interrupt request and enable flags with external edge detection
// assumes the cpu core drives accesses on core_clk and pins are asynchronous
`timescale 1ns/1ps
module irq_flags
  import irq_flags_pkg::*;
#(
  parameter int SAMPLE_DIV = SLOW_SAMPLE_DIV
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // sources and pins
  input wire int_src_t int_src,
  input wire ext_pins_t pins,
  input wire logic standby,
  // nibble memory access
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [3:0] mem_idx,
  input wire logic [3:0] mem_wdata,
  output logic [3:0] mem_rdata,
  // single-bit access
  input wire bit_op_t bit_op,
  input wire logic [4:0] bit_sel,
  output logic bit_rdata,
  // cpu acceptance
  input wire logic global_irq_enable,
  input wire logic ack_valid,
  input wire logic [2:0] ack_vrq,
  output logic [6:1] vectored_request,
  output logic [2:0] top_vrq,
  output logic [15:0] top_vec_addr,
  output logic standby_release
);

  // divider wraps on its last count, which is also the slow sample tick
  localparam int DIV_W = $clog2(SAMPLE_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

  // edge match against a 2-bit edge code
  function automatic logic edge_hit(input logic [1:0] code, input logic prv, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prv;
    fall = prv & ~cur;
    unique case (code)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      EDGE_NONE: edge_hit = 1'b0;
    endcase
  endfunction

  // key selection: codes 1..4 take the top 2,4,6,8 keys
  // any other code leaves every key out, so the combined level stays high
  function automatic logic [7:0] key_mask(input logic [3:0] code);
    unique case (code)
      4'h1: key_mask = 8'hc0;
      4'h2: key_mask = 8'hf0;
      4'h3: key_mask = 8'hfc;
      4'h4: key_mask = 8'hff;
      default: key_mask = 8'h00;
    endcase
  endfunction

  logic [11:0] sync1_reg, sync1_next;
  logic [11:0] sync2_reg, sync2_next;
  logic [11:0] prev_reg, prev_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic samp1_reg, samp1_next;
  logic samp2_reg, samp2_next;
  logic filt_reg, filt_next;
  logic filt_prev_reg, filt_prev_next;
  logic key_all_reg, key_all_next;
  logic [3:0] mode0_reg, mode0_next;
  logic [3:0] mode1_reg, mode1_next;
  logic [3:0] mode2_reg, mode2_next;
  logic [NUM_FLAGS-1:0] req_reg, req_next;
  logic [NUM_FLAGS-1:0] en_reg, en_next;
  logic [3:0] rdata_reg, rdata_next;
  logic bit_rd_reg, bit_rd_next;
  logic sample_en;
  logic [NUM_FLAGS-1:0] hw_set;
  logic [NUM_FLAGS-1:0] active;
  logic [NUM_FLAGS-1:0] ack_clr;
  logic [6:1] vrq_raw;

  // syncs clear on reset, so a pin high at release reads as a rising edge
  // two-flop synchronisers, then previous sample
  always_comb begin
    sync1_next = pins;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  // slow sample tick every SAMPLE_DIV cycles
  always_comb begin
    div_next = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
  end

  // the divider keeps counting in standby; only the sampler is frozen
  // sampling stops in standby
  assign sample_en = ~standby & (~mode0_reg[EXT0_CLK_SEL_BIT] | (div_reg == DIV_LAST));

  // a pulse no longer than one tick never gives two equal high samples
  // level passes only after two equal samples
  always_comb begin
    samp1_next = samp1_reg;
    samp2_next = samp2_reg;
    filt_next = filt_reg;
    if (sample_en) begin
      samp1_next = sync2_reg[0];
      samp2_next = samp1_reg;
      if (samp1_reg == samp2_reg) begin
        filt_next = samp2_reg;
      end
    end
    filt_prev_next = filt_reg;
  end

  // selected keys combined, low on any holds it low
  always_comb begin
    key_all_next = &(sync2_reg[11:4] | ~key_mask(mode2_reg));
  end

  // hardware set events
  // pin c and the key inputs share one request flag
  always_comb begin
    hw_set = '0;
    hw_set[F_INTERVAL] = int_src.interval_tick;
    hw_set[F_SERIAL] = int_src.serial_done;
    hw_set[F_COUNTER] = int_src.counter_match;
    hw_set[F_PULSE] = int_src.pulse_gen_match;
    hw_set[F_WATCH] = int_src.watch_tick;
    hw_set[F_DUAL] = sync2_reg[3] ^ prev_reg[3];
    // selectable edges on pins a and b
    hw_set[F_EXT0] = edge_hit(mode0_reg[1:0], filt_prev_reg, filt_reg);
    hw_set[F_EXT1] = edge_hit(mode1_reg[1:0], prev_reg[1], sync2_reg[1]);
    if (mode2_reg == MODE_RESET) begin
      hw_set[F_KEY] = sync2_reg[2] & ~prev_reg[2];
    end else begin
      hw_set[F_KEY] = key_all_reg & ~key_all_next;
    end
  end

  assign active = req_reg & en_reg;
  // vector 1 is shared by the interval timer and the dual-edge pin
  // key and watch flags give no vector
  assign vrq_raw = {active[F_PULSE], active[F_COUNTER], active[F_SERIAL], active[F_EXT1],
                    active[F_EXT0], active[F_INTERVAL] | active[F_DUAL]};

  // acceptance clears
  // with both vector 1 sources pending, software sorts them out by testing
  always_comb begin
    ack_clr = '0;
    if (ack_valid) begin
      unique case (ack_vrq)
        3'h1: begin
          // shared vector clears only a lone source
          ack_clr[F_INTERVAL] = active[F_INTERVAL] & ~active[F_DUAL];
          ack_clr[F_DUAL] = active[F_DUAL] & ~active[F_INTERVAL];
        end
        3'h2: ack_clr[F_EXT0] = 1'b1;
        3'h3: ack_clr[F_EXT1] = 1'b1;
        3'h4: ack_clr[F_SERIAL] = 1'b1;
        3'h5: ack_clr[F_COUNTER] = 1'b1;
        3'h6: ack_clr[F_PULSE] = 1'b1;
        default: ack_clr = '0;
      endcase
    end
  end

  // software accesses and flag update
  // a bit op is applied after a nibble write, so it wins on its own bit
  always_comb begin
    logic [17:0] all;
    logic [17:0] all_new;
    all = {en_reg, req_reg};
    all_new = all;
    mode0_next = mode0_reg;
    mode1_next = mode1_reg;
    mode2_next = mode2_reg;
    rdata_next = rdata_reg;
    bit_rd_next = bit_rd_reg;
    if (mem_wr) begin
      unique case (mem_idx)
        IDX_EXT0_MODE: mode0_next = mem_wdata;
        IDX_EXT1_MODE: mode1_next = mem_wdata;
        IDX_EXT2_MODE: mode2_next = mem_wdata;
        IDX_REQ_LO: all_new[3:0] = mem_wdata;
        IDX_REQ_MID: all_new[7:4] = mem_wdata;
        IDX_REQ_HI: all_new[8] = mem_wdata[0];
        IDX_EN_LO: all_new[12:9] = mem_wdata;
        IDX_EN_MID: all_new[16:13] = mem_wdata;
        IDX_EN_HI: all_new[17] = mem_wdata[0];
        default: all_new = all;
      endcase
    end
    if (mem_rd) begin
      unique case (mem_idx)
        IDX_EXT0_MODE: rdata_next = mode0_reg;
        IDX_EXT1_MODE: rdata_next = mode1_reg;
        IDX_EXT2_MODE: rdata_next = mode2_reg;
        IDX_REQ_LO: rdata_next = all[3:0];
        IDX_REQ_MID: rdata_next = all[7:4];
        IDX_REQ_HI: rdata_next = {3'h0, all[8]};
        IDX_EN_LO: rdata_next = all[12:9];
        IDX_EN_MID: rdata_next = all[16:13];
        IDX_EN_HI: rdata_next = {3'h0, all[17]};
        default: rdata_next = 4'h0;
      endcase
    end
    if (bit_op != BIT_NOP && bit_sel < 5'h12) begin
      bit_rd_next = all[bit_sel];
      unique case (bit_op)
        // software set acts as a request
        BIT_SET: all_new[bit_sel] = 1'b1;
        BIT_CLR: all_new[bit_sel] = 1'b0;
        BIT_TEST_CLR: all_new[bit_sel] = 1'b0;
        default: all_new[bit_sel] = all[bit_sel];
      endcase
    end
    en_next = all_new[17:9];
    // a source event in the clearing cycle is never lost
    // acceptance clears, hardware set wins
    req_next = (all_new[8:0] & ~ack_clr) | hw_set;
  end

  assign vectored_request = global_irq_enable ? vrq_raw : 6'h00;
  // not gated by the global enable, so a masked source still wakes the core
  // all enabled flags release standby
  assign standby_release = |active;

  // vector addresses step by two from the first table entry
  // fixed priority, lowest number first
  always_comb begin
    top_vrq = 3'h0;
    for (int i = 6; i >= 1; i--) begin
      if (vectored_request[i]) begin
        top_vrq = 3'(i);
      end
    end
    top_vec_addr = (top_vrq == 3'h0) ? 16'h0000
                 : VEC_ADDR_BASE + VEC_ADDR_STEP * 16'(top_vrq - 3'h1);
  end

  // read data stays registered until the next access of its kind
  assign mem_rdata = rdata_reg;
  assign bit_rdata = bit_rd_reg;

  // registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
      div_reg <= '0;
      samp1_reg <= 1'b0;
      samp2_reg <= 1'b0;
      filt_reg <= 1'b0;
      filt_prev_reg <= 1'b0;
      // keys idle high, so the combined level starts high
      key_all_reg <= 1'b1;
      mode0_reg <= MODE_RESET;
      mode1_reg <= MODE_RESET;
      // key mode back to pin rising
      mode2_reg <= MODE_RESET;
      req_reg <= '0;
      en_reg <= '0;
      rdata_reg <= 4'h0;
      bit_rd_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      div_reg <= div_next;
      samp1_reg <= samp1_next;
      samp2_reg <= samp2_next;
      filt_reg <= filt_next;
      filt_prev_reg <= filt_prev_next;
      key_all_reg <= key_all_next;
      mode0_reg <= mode0_next;
      mode1_reg <= mode1_next;
      mode2_reg <= mode2_next;
      req_reg <= req_next;
      en_reg <= en_next;
      rdata_reg <= rdata_next;
      bit_rd_reg <= bit_rd_next;
    end
  end

endmodule

//--- irq_flags_assertions.sv
// checker of the interrupt flag block outputs against its inputs
// assumes binding onto irq_flags, one clock core_clk, srst active high
`timescale 1ns/1ps
module irq_flags_assertions
  import irq_flags_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // watched inputs
  input wire int_src_t int_src,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire bit_op_t bit_op,
  input wire logic [4:0] bit_sel,
  input wire logic global_irq_enable,
  input wire logic ack_valid,
  input wire logic [2:0] ack_vrq,
  // watched outputs
  input wire logic [3:0] mem_rdata,
  input wire logic bit_rdata,
  input wire logic [6:1] vectored_request,
  input wire logic [2:0] top_vrq,
  input wire logic [15:0] top_vec_addr,
  input wire logic standby_release
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // no set event on the serial flag in this cycle
  sequence serial_quiet_s;
    !int_src.serial_done && bit_op != BIT_SET && !mem_wr;
  endsequence
  a_global_gate: assert property (!global_irq_enable |-> vectored_request == 6'h00)
    else $error("request while globally disabled");
  a_release_follows: assert property (vectored_request != 6'h00 |-> standby_release)
    else $error("request without standby release");
  a_top_lowest: assert property (vectored_request != 6'h00 |-> top_vrq != 3'h0
    && vectored_request[top_vrq] && ((vectored_request & ((6'h01 << (top_vrq - 3'h1)) - 6'h01))
    == 6'h00)) else $error("top vector not lowest pending");
  a_vec_addr: assert property (top_vrq != 3'h0 |-> top_vec_addr == 16'h0002
    + {12'h000, top_vrq, 1'b0} - 16'h0002) else $error("vector address wrong");
  a_after_reset: assert property ($fell(srst) |-> vectored_request == 6'h00
    && !standby_release && mem_rdata == 4'h0) else $error("outputs not clear after reset");
  a_ack_clears: assert property (ack_valid && ack_vrq == 3'h4 ##0 serial_quiet_s
    |=> !vectored_request[4]) else $error("accepted flag not cleared");
  a_test_reads: assert property (bit_op == BIT_TEST_CLR && bit_sel == 5'h04
    && vectored_request[4] |=> bit_rdata) else $error("test returned zero for set flag");
  a_test_clears: assert property (bit_op == BIT_TEST_CLR && bit_sel == 5'h04
    ##0 serial_quiet_s |=> !vectored_request[4]) else $error("test did not clear flag");
  a_rdata_stands: assert property (!mem_rd |=> $stable(mem_rdata))
    else $error("read data moved without read");
endmodule

bind irq_flags irq_flags_assertions irq_flags_assertions_i (
  .core_clk(core_clk), .srst(srst), .int_src(int_src), .mem_wr(mem_wr), .mem_rd(mem_rd),
  .bit_op(bit_op), .bit_sel(bit_sel), .global_irq_enable(global_irq_enable),
  .ack_valid(ack_valid), .ack_vrq(ack_vrq), .mem_rdata(mem_rdata), .bit_rdata(bit_rdata),
  .vectored_request(vectored_request), .top_vrq(top_vrq), .top_vec_addr(top_vec_addr),
  .standby_release(standby_release)
);

//--- cpu_ack_model.sv
// cpu core model that accepts the top pending vector
// assumes the block shows its top vector combinationally on core_clk
`timescale 1ns/1ps
module cpu_ack_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bench control: accept on/off and wait before accepting
  input wire logic accept_en,
  input wire logic [1:0] delay,
  // acceptance link
  input wire logic [2:0] top_vrq,
  output logic ack_valid,
  output logic [2:0] ack_vrq,
  output int n_acks
);
  int wait_cnt;
  initial begin
    ack_valid = 1'b0;
    ack_vrq = 3'h0;
    n_acks = 0;
    wait_cnt = 0;
  end
  // one-cycle acceptance; released vector lines toggle to stay meaningless
  // accept top vector
  always @(negedge core_clk) begin
    if (srst || ack_valid || !accept_en || top_vrq == 3'h0) begin
      ack_valid <= 1'b0;
      ack_vrq <= ~ack_vrq;
      wait_cnt <= 0;
    end else if (wait_cnt >= int'(delay)) begin
      ack_valid <= 1'b1;
      ack_vrq <= top_vrq;
      n_acks <= n_acks + 1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

//--- irq_flags_bench.sv
// self-checking bench of the interrupt flag block
// assumes 200 MHz core_clk, inputs driven at its falling edge
`timescale 1ns/1ps
module irq_flags_bench;
  import irq_flags_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  int_src_t int_src = '0;
  ext_pins_t pins = 12'hff0;
  logic standby = 1'b0;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [3:0] mem_idx = 4'h0;
  logic [3:0] mem_wdata = 4'h0;
  bit_op_t bit_op = BIT_NOP;
  logic [4:0] bit_sel = 5'h00;
  logic global_irq_enable = 1'b0;
  logic accept_en = 1'b0;
  logic [3:0] mem_rdata, rv;
  logic bit_rdata, ack_valid, standby_release, b;
  logic [2:0] ack_vrq, top_vrq;
  logic [6:1] vectored_request;
  logic [15:0] top_vec_addr;
  logic [4:0] flag_of [5] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h07};
  int failures = 0;
  int n_checks = 0;
  int n_acks, k;
  always #2.5 core_clk = ~core_clk;

  irq_flags #(.SAMPLE_DIV(4)) irq_flags_i (.core_clk(core_clk), .srst(srst),
    .int_src(int_src), .pins(pins), .standby(standby), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_idx(mem_idx), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .bit_op(bit_op),
    .bit_sel(bit_sel), .bit_rdata(bit_rdata), .global_irq_enable(global_irq_enable),
    .ack_valid(ack_valid), .ack_vrq(ack_vrq), .vectored_request(vectored_request),
    .top_vrq(top_vrq), .top_vec_addr(top_vec_addr), .standby_release(standby_release));
  cpu_ack_model cpu_ack_model_i (.core_clk(core_clk), .srst(srst), .accept_en(accept_en),
    .delay(2'h2), .top_vrq(top_vrq), .ack_valid(ack_valid), .ack_vrq(ack_vrq),
    .n_acks(n_acks));

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // nibble write, then nibble read returning data of the next cycle
  task automatic nwr(input logic [3:0] idx, input logic [3:0] d);
    @(negedge core_clk);
    mem_idx = idx;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge core_clk);
    mem_wr = 1'b0;
  endtask
  task automatic nrd(input logic [3:0] idx, output logic [3:0] v);
    @(negedge core_clk);
    mem_idx = idx;
    mem_rd = 1'b1;
    @(negedge core_clk);
    mem_rd = 1'b0;
    v = mem_rdata;
  endtask
  // single-bit operation returning the old bit
  task automatic bop(input bit_op_t op, input logic [4:0] sel, output logic v);
    @(negedge core_clk);
    bit_op = op;
    bit_sel = sel;
    @(negedge core_clk);
    bit_op = BIT_NOP;
    v = bit_rdata;
  endtask
  // toggle a pin, toggle it back after len cycles unless len is 0, then test and clear a flag
  task automatic pin(input int i, input int len, input logic [4:0] sel, input logic exp);
    @(negedge core_clk);
    pins[i] = ~pins[i];
    repeat (len) @(negedge core_clk);
    if (len > 0) pins[i] = ~pins[i];
    repeat (24) @(negedge core_clk);
    bop(BIT_TEST_CLR, sel, b);
    chk(b, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    for (k = 0; k < 9; k++) begin
      nrd(k[3:0], rv);
      chk(rv, 4'h0);
    end
    nrd(4'hf, rv);
    chk(rv, 4'h0);
    nwr(IDX_REQ_HI, 4'hf);
    nrd(IDX_REQ_HI, rv);
    chk(rv, 4'h1);
    bop(BIT_TEST_CLR, 5'h08, b);
    chk(b, 1'b1);
    $display("test reset values done");
    for (k = 0; k < 5; k++) begin
      @(negedge core_clk);
      int_src = 5'h10 >> k;
      @(negedge core_clk);
      int_src = '0;
      bop(BIT_TEST_CLR, flag_of[k], b);
      chk(b, 1'b1);
      bop(BIT_TEST_CLR, flag_of[k], b);
      chk(b, 1'b0);
    end
    $display("test internal sources done");
    nwr(IDX_EN_LO, 4'hf);
    nwr(IDX_EN_MID, 4'hf);
    nrd(IDX_EN_MID, rv);
    chk(rv, 4'hf);
    bop(BIT_TEST_CLR, 5'h10, b);
    chk(b, 1'b1);
    nrd(IDX_EN_MID, rv);
    chk(rv, 4'h7);
    bop(BIT_SET, 5'h06, b);
    bop(BIT_SET, 5'h04, b);
    bop(BIT_SET, 5'h00, b);
    chk(vectored_request, 6'h00);
    chk(standby_release, 1'b1);
    global_irq_enable = 1'b1;
    @(negedge core_clk);
    chk(vectored_request, 6'h29);
    chk(top_vrq, 3'h1);
    chk(top_vec_addr, 16'h0002);
    accept_en = 1'b1;
    for (k = 0; k < 60 && vectored_request !== 6'h00; k++) @(negedge core_clk);
    chk(vectored_request, 6'h00);
    chk(n_acks, 3);
    accept_en = 1'b0;
    bop(BIT_SET, 5'h04, b);
    bop(BIT_TEST_CLR, 5'h04, b);
    chk(b, 1'b1);
    chk(vectored_request, 6'h00);
    global_irq_enable = 1'b0;
    $display("test vectors done");
    // modes changed with interrupts off, flag cleared after
    nwr(IDX_EXT1_MODE, {2'h0, EDGE_FALL});
    bop(BIT_CLR, 5'h03, b);
    pin(1, 0, 5'h03, 1'b0);
    pin(1, 0, 5'h03, 1'b1);
    nwr(IDX_EXT1_MODE, {2'h0, EDGE_BOTH});
    pin(1, 0, 5'h03, 1'b1);
    pin(1, 0, 5'h03, 1'b1);
    nwr(IDX_EXT1_MODE, {2'h0, EDGE_NONE});
    pin(1, 0, 5'h03, 1'b0);
    pin(3, 0, 5'h01, 1'b1);
    pin(3, 0, 5'h01, 1'b1);
    pin(0, 1, 5'h02, 1'b0);
    pin(0, 3, 5'h02, 1'b1);
    nwr(IDX_EXT0_MODE, 4'h8);
    repeat (16) @(negedge core_clk);
    bop(BIT_CLR, 5'h02, b);
    pin(0, 3, 5'h02, 1'b0);
    standby = 1'b1;
    pin(0, 12, 5'h02, 1'b0);
    standby = 1'b0;
    pin(0, 12, 5'h02, 1'b1);
    $display("test pin edges done");
    pin(2, 0, 5'h08, 1'b1);
    nwr(IDX_EXT2_MODE, 4'h2);
    bop(BIT_CLR, 5'h08, b);
    pin(9, 0, 5'h08, 1'b1);
    pin(10, 0, 5'h08, 1'b0);
    pin(10, 0, 5'h08, 1'b0);
    pin(9, 0, 5'h08, 1'b0);
    pin(4, 0, 5'h08, 1'b0);
    $display("test key inputs done");
    finish_test();
  end
endmodule
